// ---- src/mmt_defines.vh ----
// Constants for the multi-mode timer block: register offsets, fields, codes.
// Assumes a byte-addressed 32-bit Avalon-MM register bus.
`ifndef MMT_DEFINES_VH
`define MMT_DEFINES_VH
`define MMT_OFF_START   8'h00
`define MMT_OFF_CUTOFF  8'h04
`define MMT_OFF_APOL    8'h08
`define MMT_OFF_ASRC    8'h0C
`define MMT_OFF_IRQ     8'h10
`define MMT_BLK_AMODE   3'h1
`define MMT_BLK_ACNT    3'h2
`define MMT_BLK_BMODE   3'h3
`define MMT_BLK_BCNT    3'h4
`define MMT_AM_TIMER    2'h0
`define MMT_AM_EVENT    2'h1
`define MMT_AM_ONESHOT  2'h2
`define MMT_AM_PWM      2'h3
`define MMT_AM_EXT      2
`define MMT_AM_UP       3
`define MMT_BM_TIMER    2'h0
`define MMT_BM_EVENT    2'h1
`define MMT_BM_MEAS     2'h2
`define MMT_BM_WIDTH    2
`define MMT_BM_RSVD     4
`define MMT_BM_CAUSE    5
`define MMT_CNT_RST     16'h0000
`define MMT_BCNT_RST    16'hFFFF
`define MMT_ALL_ONES    16'hFFFF
`endif

// ---- src/mmt_timer_units.v ----
// Five A-group and six B-group 16-bit timer channels behind an Avalon-MM slave.
// Assumes all pin inputs are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "mmt_defines.vh"

// How it works
// - After reset all eleven channels are stopped until their start bit is set.
// - A-group timer read during reload returns FFFFh.
// - Counter written while stopped reads back the written value.
// - A-group event read during reload returns FFFFh on underflow, 0000h on overflow.
// - Cutoff enabled and shutdown low puts A outputs 1, 2, 4 in high impedance.
// - Clearing start in one-shot stops counting and reloads the counter.
// - Clearing start in one-shot drives the output to its polarity bit level.
// - Clearing start in one-shot sets the interrupt flag one clock later.
// - One-shot output is aligned to count source ticks, within 1.5 ticks.
// - Entering one-shot from reset, timer or event mode sets the interrupt flag.
// - Entering PWM from reset, timer or event mode sets the interrupt flag.
// - Retrigger during one-shot counts down once, then reloads and continues.
// - PWM stop with polarity 0: high output goes low and sets the flag.
// - PWM stop with polarity 1: low output goes high and sets the flag.
// - B-group timer and event read during reload returns FFFFh.
// - B measurement flags edges and overflows; a cause bit marks overflow.
// - First measured edge after start loads reload without an interrupt.
// - B counter resets to a nonzero value, so early overflow may occur.
// - B counter written while stopped loads the counter directly.
// - Width measurement measures high and low widths alternately, unmarked.
module mmt_timer_units (
	// Clock and reset.
	input  wire        sys_clk,
	input  wire        rst_n,
	// Avalon-MM register slave.
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire        avs_waitrequest,
	// A-group pins.
	input  wire [4:0]  a_group_trigger_input,
	output wire [4:0]  a_group_output_pin,
	output wire [4:0]  a_group_output_en_n,
	input  wire        shutdown_input_n,
	// B-group pins.
	input  wire [5:0]  b_group_pulse_input,
	// Interrupt request flags.
	output wire [4:0]  a_group_irq,
	output wire [5:0]  b_group_irq
);

	reg  [31:0] readdata_ff;
	reg         waitreq_ff, cutoff_en_ff;
	reg  [4:0]  a_start_ff;
	reg  [5:0]  b_start_ff;
	reg  [4:0]  a_pol_ff;
	reg  [9:0]  a_src_ff;
	reg  [4:0]  a_out_ff, a_en_n_ff, a_irq_ff;
	reg  [5:0]  b_irq_ff;
	reg  [4:0]  presc_ff;
	reg  [31:0] rd_mux;
	wire [19:0] a_mode_flat;
	wire [79:0] a_rd_flat;
	wire [47:0] b_mode_flat;
	wire [95:0] b_rd_flat;
	wire [3:0]  tick_src;
	wire        wr_go;
	wire [15:0] wd16;
	wire [2:0]  blk, idx;

	assign avs_readdata = readdata_ff;
	assign avs_waitrequest = waitreq_ff;
	assign a_group_output_pin = a_out_ff;
	assign a_group_output_en_n = a_en_n_ff;
	assign a_group_irq = a_irq_ff;
	assign b_group_irq = b_irq_ff;

	// A write lands only on the edge where waitrequest is seen low.
	assign wr_go = avs_write & ~waitreq_ff & avs_byteenable[0];
	assign wd16 = avs_writedata[15:0];
	assign blk = avs_address[7:5];
	assign idx = avs_address[4:2];

	// Shared prescaler taps: every clock, /8, /32, /4.
	assign tick_src = {presc_ff[1:0] == 2'h3, presc_ff == 5'h1F, presc_ff[2:0] == 3'h7, 1'b1};

	// Read decode; unmapped addresses and idle indices read as zero.
	always @* begin
		rd_mux = 32'h0000_0000;
		if (avs_address == `MMT_OFF_START) begin
			rd_mux = {18'h0, b_start_ff, 3'h0, a_start_ff};
		end else if (avs_address == `MMT_OFF_CUTOFF) begin
			rd_mux = {31'h0, cutoff_en_ff};
		end else if (avs_address == `MMT_OFF_APOL) begin
			rd_mux = {27'h0, a_pol_ff};
		end else if (avs_address == `MMT_OFF_ASRC) begin
			rd_mux = {22'h0, a_src_ff};
		end else if (avs_address == `MMT_OFF_IRQ) begin
			rd_mux = {18'h0, b_irq_ff, 3'h0, a_irq_ff};
		end else if (blk == `MMT_BLK_AMODE && idx < 3'h5) begin
			rd_mux = {28'h0, a_mode_flat[{idx, 2'h0} +: 4]};
		end else if (blk == `MMT_BLK_ACNT && idx < 3'h5) begin
			rd_mux = {16'h0, a_rd_flat[{idx, 4'h0} +: 16]};
		end else if (blk == `MMT_BLK_BMODE && idx < 3'h6) begin
			rd_mux = {24'h0, b_mode_flat[{idx, 3'h0} +: 8]};
		end else if (blk == `MMT_BLK_BCNT && idx < 3'h6) begin
			rd_mux = {16'h0, b_rd_flat[{idx, 4'h0} +: 16]};
		end
	end

	// Bus handshake: one wait cycle, then data with waitrequest low.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			waitreq_ff <= 1'b1;
			readdata_ff <= 32'h0000_0000;
		end else if (waitreq_ff && (avs_read || avs_write)) begin
			waitreq_ff <= 1'b0;
			readdata_ff <= rd_mux; // Sampled now so a reload coincidence is seen.
		end else begin
			waitreq_ff <= 1'b1;
		end
	end

	// Shared control registers; start bits clear to stop all channels.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			a_start_ff <= 5'h00;
			b_start_ff <= 6'h00;
			cutoff_en_ff <= 1'b0;
			a_pol_ff <= 5'h00;
			a_src_ff <= 10'h000;
			presc_ff <= 5'h00;
			a_en_n_ff <= 5'h1F;
		end else begin
			presc_ff <= presc_ff + 5'h01;
			if (wr_go && avs_address == `MMT_OFF_START) begin
				a_start_ff <= avs_writedata[4:0];
				b_start_ff <= avs_writedata[13:8];
			end
			if (wr_go && avs_address == `MMT_OFF_CUTOFF)
				cutoff_en_ff <= avs_writedata[0];
			if (wr_go && avs_address == `MMT_OFF_APOL)
				a_pol_ff <= avs_writedata[4:0];
			if (wr_go && avs_address == `MMT_OFF_ASRC)
				a_src_ff <= avs_writedata[9:0];
			// Cutoff releases outputs 1, 2 and 4 in every mode.
			a_en_n_ff <= {cutoff_en_ff & ~shutdown_input_n, 1'b0,
				{2{cutoff_en_ff & ~shutdown_input_n}}, 1'b0};
		end
	end

	genvar i;
	// A-group channels.
	generate
		for (i = 0; i < 5; i = i + 1) begin : g_a
			reg  [3:0]  mode_ff;
			reg  [15:0] cnt_ff, rld_ff;
			reg         trig_prev_ff, start_prev_ff, run_ff, pend_ff, retrig_ff, stop_irq_ff;
			wire [1:0]  md;
			wire        started, tick, trig_edge, stop_evt, go_trig, act, up, wr_mode;
			wire        wr_cnt, reload_now, os_end, pwm_end, pwm_stop, mode_irq, hw_set, sw_clr;
			wire [15:0] pwm_next;

			assign md = mode_ff[1:0];
			assign started = a_start_ff[i];
			assign tick = tick_src[a_src_ff[2*i+1 -: 2]];
			assign trig_edge = a_group_trigger_input[i] & ~trig_prev_ff;
			assign stop_evt = start_prev_ff & ~started;
			assign act = ~a_pol_ff[i];
			assign up = mode_ff[`MMT_AM_UP];
			// Trigger is the input edge or the start bit rising.
			assign go_trig = mode_ff[`MMT_AM_EXT] ? trig_edge : (started & ~start_prev_ff);
			assign wr_mode = wr_go && blk == `MMT_BLK_AMODE && idx == i;
			assign wr_cnt = wr_go && blk == `MMT_BLK_ACNT && idx == i;
			assign pwm_next = (cnt_ff == 16'h0000) ? `MMT_ALL_ONES : cnt_ff - 16'h0001;
			assign reload_now = started && (
				(md == `MMT_AM_TIMER && tick && cnt_ff == 16'h0000) ||
				(md == `MMT_AM_EVENT && trig_edge &&
					cnt_ff == (up ? `MMT_ALL_ONES : 16'h0000)));
			assign os_end = started && md == `MMT_AM_ONESHOT && tick && run_ff &&
				!pend_ff && !retrig_ff && cnt_ff == 16'h0000;
			assign pwm_end = started && md == `MMT_AM_PWM && tick && run_ff &&
				a_out_ff[i] == act && pwm_next >= rld_ff;
			assign pwm_stop = stop_evt && md == `MMT_AM_PWM && a_out_ff[i] == act;
			// Moving from timer or event into one-shot or PWM raises the flag.
			assign mode_irq = wr_mode && avs_writedata[1] && !md[1];
			assign hw_set = mode_irq | stop_irq_ff | reload_now | os_end | pwm_end | pwm_stop;
			assign sw_clr = wr_go && avs_address == `MMT_OFF_IRQ && !avs_writedata[i];

			// Reads during a reload show the reload marker, else the live count.
			assign a_rd_flat[16*i+15 -: 16] = !reload_now ? cnt_ff :
				(md == `MMT_AM_EVENT && up) ? 16'h0000 : `MMT_ALL_ONES;
			assign a_mode_flat[4*i+3 -: 4] = mode_ff;

			// Flag stays until written 0; a coincident hardware set wins.
			always @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n)
					a_irq_ff[i] <= 1'b0;
				else if (hw_set)
					a_irq_ff[i] <= 1'b1;
				else if (sw_clr)
					a_irq_ff[i] <= 1'b0;
			end

			// Channel counter, output and one-shot sequencing.
			always @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					mode_ff <= 4'h0;
					cnt_ff <= `MMT_CNT_RST;
					rld_ff <= `MMT_CNT_RST;
					trig_prev_ff <= 1'b0;
					start_prev_ff <= 1'b0;
					run_ff <= 1'b0;
					pend_ff <= 1'b0;
					retrig_ff <= 1'b0;
					stop_irq_ff <= 1'b0;
					a_out_ff[i] <= 1'b0;
				end else begin
					trig_prev_ff <= a_group_trigger_input[i];
					start_prev_ff <= started;
					stop_irq_ff <= stop_evt && md == `MMT_AM_ONESHOT;
					if (wr_mode)
						mode_ff <= avs_writedata[3:0];
					if (wr_cnt) begin
						rld_ff <= wd16;
						if (!started)
							cnt_ff <= wd16;
					end
					if (!started) begin
						run_ff <= 1'b0;
						pend_ff <= 1'b0;
						retrig_ff <= 1'b0;
						if (stop_evt && md == `MMT_AM_ONESHOT) begin
							cnt_ff <= rld_ff;
							a_out_ff[i] <= a_pol_ff[i];
						end else if (pwm_stop) begin
							a_out_ff[i] <= a_pol_ff[i];
						end
					end else begin
						case (md)
						`MMT_AM_TIMER: begin
							if (tick)
								cnt_ff <= reload_now ? rld_ff : cnt_ff - 16'h0001;
						end
						`MMT_AM_EVENT: begin
							if (reload_now)
								cnt_ff <= rld_ff;
							else if (trig_edge)
								cnt_ff <= up ? cnt_ff + 16'h0001 : cnt_ff - 16'h0001;
						end
						`MMT_AM_ONESHOT: begin
							// Output moves only on a tick, so it follows the count source.
							if (tick) begin
								if (pend_ff) begin
									pend_ff <= 1'b0;
									run_ff <= 1'b1;
									cnt_ff <= rld_ff;
									a_out_ff[i] <= act;
								end else if (run_ff) begin
									if (retrig_ff) begin
										retrig_ff <= 1'b0;
										cnt_ff <= rld_ff;
									end else if (cnt_ff == 16'h0000) begin
										run_ff <= 1'b0;
										cnt_ff <= rld_ff;
										a_out_ff[i] <= a_pol_ff[i];
									end else begin
										cnt_ff <= cnt_ff - 16'h0001;
									end
								end
							end
							// Trigger capture comes last so a tick never drops it.
							if (go_trig && run_ff)
								retrig_ff <= 1'b1;
							else if (go_trig)
								pend_ff <= 1'b1;
						end
						default: begin
							// PWM: fixed 65536-tick period, active while count < reload.
							if (go_trig)
								run_ff <= 1'b1;
							if (tick && run_ff) begin
								cnt_ff <= pwm_next;
								a_out_ff[i] <= (pwm_next < rld_ff) ? act : ~act;
							end
						end
						endcase
					end
				end
			end
		end
	endgenerate

	// B-group channels.
	generate
		for (i = 0; i < 6; i = i + 1) begin : g_b
			reg  [7:0]  mode_ff;
			reg  [15:0] cnt_ff, rld_ff;
			reg         cause_ff, in_prev_ff, start_prev_ff, first_ff;
			wire [1:0]  md;
			wire        started, tick, rise, meas_edge, meas, ovf;
			wire        wr_mode, wr_cnt, reload_now, hw_set, sw_clr;

			assign md = mode_ff[1:0];
			assign started = b_start_ff[i];
			assign tick = tick_src[mode_ff[7:6]];
			assign rise = b_group_pulse_input[i] & ~in_prev_ff;
			assign meas = started && md == `MMT_BM_MEAS;
			// Width mode takes both edges, so high and low widths alternate.
			assign meas_edge = meas && (mode_ff[`MMT_BM_WIDTH] ?
				(b_group_pulse_input[i] ^ in_prev_ff) : rise);
			assign ovf = meas && !meas_edge && tick && cnt_ff == `MMT_ALL_ONES;
			assign wr_mode = wr_go && blk == `MMT_BLK_BMODE && idx == i;
			assign wr_cnt = wr_go && blk == `MMT_BLK_BCNT && idx == i;
			assign reload_now = started && cnt_ff == 16'h0000 && (
				(md == `MMT_BM_TIMER && tick) || (md == `MMT_BM_EVENT && rise));
			// The first edge after start only loads the capture register.
			assign hw_set = reload_now | ovf | (meas_edge & ~first_ff);
			assign sw_clr = wr_go && avs_address == `MMT_OFF_IRQ && !avs_writedata[8+i];

			// Measurement reads the captured value; others read FFFFh during a reload, else the live count.
			assign b_rd_flat[16*i+15 -: 16] = (md == `MMT_BM_MEAS) ? rld_ff :
				reload_now ? `MMT_ALL_ONES : cnt_ff;
			assign b_mode_flat[8*i+7 -: 8] = {mode_ff[7:6], cause_ff, 1'b0, mode_ff[3:0]};

			// Flag stays until written 0; a coincident hardware set wins.
			always @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n)
					b_irq_ff[i] <= 1'b0;
				else if (hw_set)
					b_irq_ff[i] <= 1'b1;
				else if (sw_clr)
					b_irq_ff[i] <= 1'b0;
			end

			// Cause bit: set on overflow, cleared by a mode write with it at 0.
			always @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n)
					cause_ff <= 1'b0;
				else if (ovf)
					cause_ff <= 1'b1;
				else if (wr_mode && !avs_writedata[`MMT_BM_CAUSE])
					cause_ff <= 1'b0;
			end

			// Counter, capture and mode storage.
			always @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					mode_ff <= 8'h00;
					cnt_ff <= `MMT_BCNT_RST;
					rld_ff <= `MMT_BCNT_RST;
					in_prev_ff <= 1'b0;
					start_prev_ff <= 1'b0;
					first_ff <= 1'b1;
				end else begin
					in_prev_ff <= b_group_pulse_input[i];
					start_prev_ff <= started;
					// While running, a mode write can only clear the cause bit.
					if (wr_mode && !started)
						mode_ff <= {avs_writedata[7:6], 2'h0, avs_writedata[3:0]};
					if (started && !start_prev_ff)
						first_ff <= 1'b1;
					if (wr_cnt) begin
						rld_ff <= wd16;
						if (!started)
							cnt_ff <= wd16;
					end else if (started) begin
						case (md)
						`MMT_BM_TIMER: begin
							if (tick)
								cnt_ff <= reload_now ? rld_ff : cnt_ff - 16'h0001;
						end
						`MMT_BM_EVENT: begin
							if (rise)
								cnt_ff <= reload_now ? rld_ff : cnt_ff - 16'h0001;
						end
						`MMT_BM_MEAS: begin
							if (meas_edge) begin
								rld_ff <= cnt_ff;
								cnt_ff <= 16'h0000;
								first_ff <= 1'b0;
							end else if (tick) begin
								cnt_ff <= cnt_ff + 16'h0001;
							end
						end
						default: cnt_ff <= cnt_ff;
						endcase
					end
				end
			end
		end
	endgenerate
endmodule // mmt_timer_units
`default_nettype wire

// ---- verification/mmt_pin_model.sv ----
// Far-side pin model: single-cycle A triggers and a B square wave of 16 cycles.
// Assumes the lines it leaves alone are pulled low.
`timescale 1ns/1ps
`default_nettype none
module mmt_pin_model (
	// Clock and reset.
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Bench commands.
	input  wire logic [4:0] fire,
	input  wire logic [5:0] b_on,
	// Pins toward the block.
	output var  logic [4:0] trig_ff,
	output wire logic [5:0] b_pulse
);
	logic [1:0] gap_ff;
	logic [2:0] half_ff;
	logic       wave_ff;
	assign b_pulse = b_on & {6{wave_ff}};
	// A trigger asked for in the quiet gap is dropped, so retriggers stay apart.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_ff <= 5'h00;
			gap_ff  <= 2'h0;
			half_ff <= 3'h0;
			wave_ff <= 1'b0;
		end else begin
			trig_ff <= (gap_ff == 2'h0) ? fire : 5'h00;
			gap_ff  <= (gap_ff != 2'h0) ? gap_ff - 2'h1 : {2{|fire}};
			half_ff <= (b_on == 6'h00) ? 3'h0 : half_ff + 3'h1;
			wave_ff <= (b_on != 6'h00) && (wave_ff ^ (half_ff == 3'h7));
		end
	end
endmodule // mmt_pin_model
`default_nettype wire

// ---- verification/mmt_timer_asserts.sv ----
// Checker for the timer block: bus handshake, output cutoff and flag behaviour.
// Assumes a bind onto mmt_timer_units; only that module's ports are seen.
`timescale 1ns/1ps
`default_nettype none
`include "mmt_defines.vh"
module mmt_timer_asserts (
	// Clock and reset.
	input wire logic        sys_clk,
	input wire logic        rst_n,
	// Register bus.
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Pins and flags.
	input wire logic [4:0]  a_group_output_pin,
	input wire logic [4:0]  a_group_output_en_n,
	input wire logic        shutdown_input_n,
	input wire logic [4:0]  a_group_irq,
	input wire logic [5:0]  b_group_irq
);
	wire        wdone = avs_write && !avs_waitrequest && avs_byteenable[0];
	wire        irq_wr = wdone && avs_address == `MMT_OFF_IRQ;
	wire [13:0] clr_m = irq_wr ? ~avs_writedata[13:0] : 14'h0000;
	logic [13:0] start_ff;
	logic        cut_ff;
	logic        pol0_ff;
	logic [1:0]  m0_ff;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Shadow copies of control bits; a write lands at the edge that ends it.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_ff <= 14'h0000;
			cut_ff   <= 1'b0;
			pol0_ff  <= 1'b0;
			m0_ff    <= 2'h0;
		end else if (wdone) begin
			if (avs_address == `MMT_OFF_START)
				start_ff <= avs_writedata[13:0];
			if (avs_address == `MMT_OFF_CUTOFF)
				cut_ff <= avs_writedata[0];
			if (avs_address == `MMT_OFF_APOL)
				pol0_ff <= avs_writedata[0];
			if (avs_address == 8'h20)
				m0_ff <= avs_writedata[1:0];
		end
	end
	wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered");
	rd_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
		else $error("read data upper half set");
	cut_hiz_a: assert property (
		(cut_ff && !shutdown_input_n) [*3] |-> (a_group_output_en_n & 5'h16) == 5'h16)
		else $error("cutoff left a pin driven");
	en_idle_a: assert property (
		(!cut_ff || shutdown_input_n) [*3] |-> a_group_output_en_n == 5'h00)
		else $error("pin released without cutoff");
	a_hold_a: assert property (
		($past(a_group_irq) & ~a_group_irq & ~$past(clr_m[4:0])) == 5'h00)
		else $error("A flag dropped without a clear");
	b_hold_a: assert property (
		($past(b_group_irq) & ~b_group_irq & ~$past(clr_m[13:8])) == 6'h00)
		else $error("B flag dropped without a clear");
	b_idle_a: assert property (
		start_ff[13:8] == 6'h00 && $past(start_ff[13:8]) == 6'h00
		|-> (b_group_irq & ~$past(b_group_irq)) == 6'h00)
		else $error("stopped B channel raised a flag");
	os_flag_a: assert property (
		m0_ff == `MMT_AM_ONESHOT && $fell(start_ff[0]) |-> ##2 a_group_irq[0])
		else $error("one-shot stop left flag clear");
	os_level_a: assert property (
		m0_ff == `MMT_AM_ONESHOT && $fell(start_ff[0]) |-> ##[0:1] a_group_output_pin[0] == pol0_ff)
		else $error("one-shot stop level wrong");
	pwm_level_a: assert property (
		m0_ff == `MMT_AM_PWM && $fell(start_ff[0]) |-> ##[0:1] a_group_output_pin[0] == pol0_ff)
		else $error("PWM stop level wrong");
	cover property (irq_wr);
	cover property (cut_ff && !shutdown_input_n);
	cover property (m0_ff == `MMT_AM_PWM && $fell(start_ff[0]));
endmodule // mmt_timer_asserts
bind mmt_timer_units mmt_timer_asserts i_mmt_timer_asserts (
	.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.a_group_output_pin(a_group_output_pin), .a_group_output_en_n(a_group_output_en_n),
	.shutdown_input_n(shutdown_input_n), .a_group_irq(a_group_irq), .b_group_irq(b_group_irq)
);
`default_nettype wire

// ---- verification/mmt_timer_units_tb_top.sv ----
// Bench for the timer block: Avalon tasks, pin model, directed and random checks.
// Assumes the design, its header, the checker and the pin model compile first.
`timescale 1ns/1ps
`default_nettype none
`include "mmt_defines.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
$display("BAD %0t got %h exp %h", $time, g, e); end end
module mmt_timer_units_tb_top;
	logic        sys_clk, rst_n, avs_read, avs_write, shutdown_input_n, out0;
	logic [7:0]  avs_address, adr;
	logic [31:0] avs_writedata, q;
	logic [3:0]  avs_byteenable;
	logic [4:0]  fire;
	logic [5:0]  b_on;
	logic [15:0] seed;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest;
	wire  [4:0]  a_group_trigger_input, a_group_output_pin, a_group_output_en_n, a_group_irq;
	wire  [5:0]  b_group_pulse_input, b_group_irq;
	int          errors, comparisons;
	mmt_timer_units i_mmt_timer_units (.sys_clk(sys_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.a_group_trigger_input(a_group_trigger_input), .a_group_output_pin(a_group_output_pin),
		.a_group_output_en_n(a_group_output_en_n), .shutdown_input_n(shutdown_input_n),
		.b_group_pulse_input(b_group_pulse_input), .a_group_irq(a_group_irq),
		.b_group_irq(b_group_irq));
	mmt_pin_model i_mmt_pin_model (.sys_clk(sys_clk), .rst_n(rst_n), .fire(fire),
		.b_on(b_on), .trig_ff(a_group_trigger_input), .b_pulse(b_group_pulse_input));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// A hung wait still reaches the verdict, counted as a mismatch.
	task automatic hang;
		errors++;
		$display("BAD %0t wait ran out", $time);
		conclude;
	endtask
	// One bus transfer, held until waitrequest is seen low at a rising edge.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= !w;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) begin
			if (++n > 20)
				hang;
			@(posedge sys_clk);
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Waits for channel 0's output (k=0) or B flag (k=1) to reach v.
	task automatic wt(input int k, input logic v, input int max);
		int n = 0;
		while ((k == 0 ? a_group_output_pin[0] : b_group_irq[0]) !== v) begin
			if (++n > max)
				hang;
			@(posedge sys_clk);
		end
	endtask
	task automatic fin(input string s);
		$display("test %s over, mismatches %0d", s, errors);
	endtask
	task automatic pulse;
		fire <= 5'h01;
		@(posedge sys_clk);
		fire <= 5'h00;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// Main sequence; mode, source and polarity change only while stopped.
	initial begin
		{rst_n, avs_read, avs_write, fire, b_on, avs_address, avs_writedata} = '0;
		{avs_byteenable, shutdown_input_n, seed} = {4'hF, 1'b1, 16'h0062};
		{errors, comparisons} = '0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		cyc(30);
		`CHK(a_group_irq, 5'h00)
		rd(8'h40, 32'h0);
		rd(8'h80, 32'hFFFF);
		rd(8'hFC, 32'h0);
		for (int i = 0; i < 11; i++) begin
			seed = lfsr(seed);
			adr = (i < 5) ? 8'(8'h40 + 4 * i) : 8'(8'h6C + 4 * i);
			wr(adr, {16'h0, seed});
			rd(adr, {16'h0, seed});
		end
		fin("reset");
		for (int i = 1; i < 5; i++) begin
			if (i == 2 || i == 3)
				wr(8'(8'h20 + 4 * i), 32'h1);
			wr(8'(8'h20 + 4 * i), (i % 2) ? 32'h3 : 32'h2);
		end
		rd(`MMT_OFF_IRQ, 32'h1E);
		wr(`MMT_OFF_IRQ, 32'h3FFF);
		`CHK(a_group_irq, 5'h1E)
		wr(`MMT_OFF_IRQ, 32'h0);
		`CHK(a_group_irq, 5'h00)
		fin("flags");
		wr(`MMT_OFF_APOL, 32'h1);
		wr(8'h20, 32'h2);
		wr(8'h40, 32'h64);
		wr(`MMT_OFF_IRQ, 32'h0);
		wr(`MMT_OFF_START, 32'h1);
		cyc(10);
		bus(1'b0, 8'h40, 32'h0);
		`CHK(q[15:0] < 16'h64, 1'b1)
		wr(`MMT_OFF_START, 32'h0);
		cyc(2);
		`CHK(a_group_irq[0], 1'b1)
		`CHK(a_group_output_pin[0], 1'b1)
		rd(8'h40, 32'h64);
		wr(8'h20, 32'h6);
		wr(`MMT_OFF_APOL, 32'h0);
		wr(8'h40, 32'h14);
		wr(`MMT_OFF_START, 32'h1);
		pulse;
		wt(0, 1'b1, 4);
		cyc(10);
		pulse;
		cyc(15);
		`CHK(a_group_output_pin[0], 1'b1)
		wt(0, 1'b0, 20);
		wr(`MMT_OFF_START, 32'h0);
		fin("one_shot");
		for (int p = 0; p < 2; p++) begin
			wr(8'h20, 32'h3);
			wr(`MMT_OFF_APOL, 32'(p));
			wr(8'h40, 32'h8000);
			wr(`MMT_OFF_START, 32'h1);
			wr(`MMT_OFF_IRQ, 32'h0);
			out0 = a_group_output_pin[0];
			wr(`MMT_OFF_START, 32'h0);
			cyc(2);
			`CHK(a_group_output_pin[0], p[0])
			`CHK(a_group_irq[0], out0 ^ p[0])
		end
		wr(`MMT_OFF_CUTOFF, 32'h1);
		for (int s = 0; s < 3; s++) begin
			if (s == 2)
				wr(`MMT_OFF_CUTOFF, 32'h0);
			shutdown_input_n <= (s == 1);
			cyc(3);
			`CHK(a_group_output_en_n, (s == 0) ? 5'h16 : 5'h00)
		end
		shutdown_input_n <= 1'b1;
		wr(8'h24, 32'h1);
		wr(8'h44, 32'h3);
		wr(`MMT_OFF_START, 32'h2);
		repeat (5) begin
			fire <= 5'h02;
			cyc(1);
			fire <= 5'h00;
			cyc(5);
		end
		rd(8'h44, 32'h2);
		`CHK(a_group_irq[1], 1'b1)
		wr(`MMT_OFF_START, 32'h0);
		fin("pwm_cutoff");
		wr(8'h80, 32'hFFF0);
		wr(8'h60, 32'h2);
		wr(`MMT_OFF_START, 32'h100);
		wt(1, 1'b1, 40);
		rd(8'h60, 32'h22);
		wr(8'h60, 32'h2);
		rd(8'h60, 32'h2);
		wr(`MMT_OFF_IRQ, 32'h0);
		b_on <= 6'h01;
		cyc(12);
		`CHK(b_group_irq[0], 1'b0)
		wt(1, 1'b1, 20);
		rd(8'h60, 32'h2);
		b_on <= 6'h00;
		wr(`MMT_OFF_START, 32'h0);
		wr(8'h60, 32'h6);
		wr(`MMT_OFF_START, 32'h100);
		wr(`MMT_OFF_IRQ, 32'h0);
		b_on <= 6'h01;
		wt(1, 1'b1, 30);
		wr(`MMT_OFF_IRQ, 32'h0);
		wt(1, 1'b1, 9);
		b_on <= 6'h00;
		wr(`MMT_OFF_START, 32'h0);
		fin("measure");
		conclude;
	end
endmodule // mmt_timer_units_tb_top
`default_nettype wire
